// File: wrs_pkg.sv
// Purpose: Constants for the word readout sequencer.
// Assumes: One 100 MHz clock; times are converted to cycles in the module.
// Notes: Times are kept in their own units; cycle counts are derived.
// What this block does
// - 25 pending flags, toggled by final channel mark
// - Each flag ANDed with its own scan line
// - Six-bit decimal counter decodes to one of 25
// - Scan counter advances at 80 kHz, holding during inhibit
// - Coincidence rising edge starts 10 us transfer
// - 10 us clear follows transfer, same word
// - Inhibit starts with transfer, blocks scan clock
// - Inhibit made of three chained 100 ms stages
// - End of conversion gives 25 us print, clears permit
// - Print-selected: cleared permit blocks until enable pulse
// - Print-all: permit ignored, every conversion prints unless a lockout is set or a print is still active
// - Either lockout always suppresses print commands
// - Scan count shown as current word number
// - 21-stage hold register, bit k to stage k
// - Transfer only sets hold stages, never clears
// - Shift moves bits up; top stage is serial out
// - After 21 shifts hold register is all zero
// - 96 inverted marks picked from 256 by configuration
// - Clear pulse resets cells of transferred word
// - Clear pulse also starts the converter clock

package wrs_pkg;

	// --------------------------------------------------------------
	// Sizes
	// --------------------------------------------------------------
	localparam int NUM_WORDS = 25;
	localparam int HOLD_BITS = 21;
	localparam int MARKS_OUT = 96;
	localparam int MARKS_IN = 256;
	localparam int MARK_IDX_W = 8;

	// --------------------------------------------------------------
	// Timing, in the units printed
	// --------------------------------------------------------------
	localparam int CLK_HZ_DEF = 100000000;
	localparam int HZ_PER_MHZ = 1000000;
	localparam int SCAN_HZ = 80000;
	localparam int XFER_US = 10;
	localparam int CLEAR_US = 10;
	localparam int PRINT_US = 25;
	localparam int INHIB_STAGE_MS = 100;
	localparam int INHIB_STAGES = 3;
	localparam int CYC_PER_MS_DEF = CLK_HZ_DEF / 1000;
	localparam int INHIB_STAGE_CYC_DEF = INHIB_STAGE_MS * CYC_PER_MS_DEF;

	// --------------------------------------------------------------
	// Decimal scan counter encoding
	// --------------------------------------------------------------
	localparam logic [3:0] UNITS_MAX = 4'h9;
	localparam logic [1:0] TENS_LAST = 2'h2;
	localparam logic [3:0] UNITS_LAST = 4'h4;
	localparam logic [4:0] DEC_BASE = 5'h0a;
	localparam logic [5:0] SCAN_RESET = 6'h00;

	// Readout sequence states
	typedef enum logic [1:0] {
		WRS_IDLE = 2'b00,
		WRS_XFER = 2'b01,
		WRS_CLEAR = 2'b10
	} wrs_state_e;

endpackage : wrs_pkg

// File: wrs_readout_seq.sv
// Purpose: Scans word-full flags, sequences transfer, clear, inhibit and print.
// Assumes: All inputs synchronous to CLK; END_CONV, SHIFT_PULSE, SELECT_EN are pulses.
// Notes: MEM_WORD is the OR of the selected cells, valid while XFER_SEL is active.
`timescale 1ns/100ps

module wrs_readout_seq #(
	parameter int CLK_HZ = wrs_pkg::CLK_HZ_DEF,
	parameter int INHIB_STAGE_CYC = wrs_pkg::INHIB_STAGE_CYC_DEF
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Memory side
	input wire logic [wrs_pkg::NUM_WORDS-1:0] WORD_DONE,
	input wire logic [wrs_pkg::HOLD_BITS-1:0] MEM_WORD,
	output logic [wrs_pkg::NUM_WORDS-1:0] XFER_SEL,
	output logic [wrs_pkg::NUM_WORDS-1:0] CLEAR_SEL,
	output logic [wrs_pkg::NUM_WORDS-1:0] PENDING,
	// Channel marks
	input wire logic [wrs_pkg::MARKS_IN-1:0] CHAN_MARK,
	input wire logic [wrs_pkg::MARKS_OUT*wrs_pkg::MARK_IDX_W-1:0] MARK_SEL,
	output logic [wrs_pkg::MARKS_OUT-1:0] CHAN_MARK_N,
	// Converter side
	input wire logic SHIFT_PULSE,
	input wire logic END_CONV,
	output logic CONV_START,
	output logic SER_BIT,
	// Printer and panel
	input wire logic PRINT_ALL,
	input wire logic SEQ4_LOCK,
	input wire logic SYNC_LOCK,
	input wire logic SELECT_EN,
	output logic PRINT_CMD,
	output logic INHIBIT,
	output logic [5:0] WORD_NUM
);

	// --------------------------------------------------------------
	// Derived cycle counts
	// --------------------------------------------------------------
	localparam int CYC_US = CLK_HZ / wrs_pkg::HZ_PER_MHZ;
	localparam int XFER_N = wrs_pkg::XFER_US * CYC_US;
	localparam int CLEAR_N = wrs_pkg::CLEAR_US * CYC_US;
	localparam int PRINT_N = wrs_pkg::PRINT_US * CYC_US;
	localparam int SCAN_N = CLK_HZ / wrs_pkg::SCAN_HZ;
	localparam int XFER_M1 = XFER_N - 1;
	localparam int CLEAR_M1 = CLEAR_N - 1;

	// Refuse rates the 16-bit counters cannot serve
	if (CLK_HZ < wrs_pkg::HZ_PER_MHZ || PRINT_N > 65535 || SCAN_N > 65535 || INHIB_STAGE_CYC < 1) begin : g_chk
		$error("wrs_readout_seq: unsupported clock rate or inhibit stage length");
	end

	// --------------------------------------------------------------
	// Functions
	// --------------------------------------------------------------
	// Decimal scan value to one-hot scan line
	function automatic logic [wrs_pkg::NUM_WORDS-1:0] scan_line(input logic [5:0] bcd);
		logic [4:0] idx;
		idx = 5'({3'h0, bcd[5:4]} * wrs_pkg::DEC_BASE) + {1'b0, bcd[3:0]};
		scan_line = {{(wrs_pkg::NUM_WORDS-1){1'b0}}, 1'b1} << idx;
	endfunction : scan_line

	// Decimal increment wrapping after the last word
	function automatic logic [5:0] scan_inc(input logic [5:0] bcd);
		if (bcd[5:4] == wrs_pkg::TENS_LAST && bcd[3:0] == wrs_pkg::UNITS_LAST) begin
			scan_inc = wrs_pkg::SCAN_RESET;
		end else if (bcd[3:0] == wrs_pkg::UNITS_MAX) begin
			scan_inc = {bcd[5:4] + 2'h1, 4'h0};
		end else begin
			scan_inc = {bcd[5:4], bcd[3:0] + 4'h1};
		end
	endfunction : scan_inc

	// --------------------------------------------------------------
	// State
	// --------------------------------------------------------------
	wrs_pkg::wrs_state_e state_reg;
	logic [wrs_pkg::NUM_WORDS-1:0] pend_reg;
	logic [wrs_pkg::NUM_WORDS-1:0] xsel_reg;
	logic [wrs_pkg::NUM_WORDS-1:0] csel_reg;
	logic [wrs_pkg::HOLD_BITS-1:0] hold_reg;
	logic [wrs_pkg::MARKS_OUT-1:0] mark_n_reg;
	logic [5:0] scan_reg;
	logic [15:0] div_reg;
	logic [15:0] seq_cnt_reg;
	logic [15:0] prt_cnt_reg;
	logic [31:0] inh_cnt_reg;
	logic [1:0] inh_stage_reg;
	logic inh_reg;
	logic hit_d_reg;
	logic conv_reg;
	logic prt_reg;
	logic permit_reg;
	logic [wrs_pkg::NUM_WORDS-1:0] coinc;
	logic hit;
	logic start;
	logic tick;
	logic print_go;

	// Coincidence of pending flags with the scan line, then the wide OR
	assign coinc = pend_reg & scan_line(scan_reg);
	assign hit = |coinc;
	// Only a rising coincidence starts a sequence; a held one cannot retrigger
	assign start = hit && !hit_d_reg && state_reg == wrs_pkg::WRS_IDLE && !inh_reg;
	assign tick = div_reg == 16'(SCAN_N - 1);
	// Print gate: lockouts first, then permit unless printing all
	assign print_go = END_CONV && !prt_reg && !SEQ4_LOCK && !SYNC_LOCK && (PRINT_ALL || permit_reg);

	// Outputs straight from flip-flops
	assign PENDING = pend_reg;
	assign XFER_SEL = xsel_reg;
	assign CLEAR_SEL = csel_reg;
	assign CONV_START = conv_reg;
	assign SER_BIT = hold_reg[wrs_pkg::HOLD_BITS-1];
	assign PRINT_CMD = prt_reg;
	assign INHIBIT = inh_reg;
	assign WORD_NUM = scan_reg;
	assign CHAN_MARK_N = mark_n_reg;

	// --------------------------------------------------------------
	// Scan oscillator and decimal counter
	// --------------------------------------------------------------
	// Free-running 80 kHz enable
	always_ff @(posedge CLK) begin
		if (RST || tick) begin
			div_reg <= 16'h0000;
		end else begin
			div_reg <= div_reg + 16'h0001;
		end
	end

	// Counter holds during inhibit and steps on from the serviced word after
	always_ff @(posedge CLK) begin
		if (RST) begin
			scan_reg <= wrs_pkg::SCAN_RESET;
		end else if (tick && !inh_reg) begin
			scan_reg <= scan_inc(scan_reg);
		end
	end

	// --------------------------------------------------------------
	// Pending flags
	// --------------------------------------------------------------
	// A final channel mark in the clear cycle still toggles: the event wins
	always_ff @(posedge CLK) begin
		if (RST) begin
			pend_reg <= '0;
		end else begin
			pend_reg <= (pend_reg & ~(state_reg == wrs_pkg::WRS_CLEAR ? csel_reg : '0)) ^ WORD_DONE;
		end
	end

	// --------------------------------------------------------------
	// Transfer and clear sequence
	// --------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (RST) begin
			hit_d_reg <= 1'b0;
		end else begin
			hit_d_reg <= hit;
		end
	end

	// Transfer for XFER_N cycles, then clear for CLEAR_N cycles
	always_ff @(posedge CLK) begin
		if (RST) begin
			state_reg <= wrs_pkg::WRS_IDLE;
			seq_cnt_reg <= 16'h0000;
			xsel_reg <= '0;
			csel_reg <= '0;
			conv_reg <= 1'b0;
		end else begin
			conv_reg <= 1'b0;
			case (state_reg)
				wrs_pkg::WRS_IDLE: begin
					if (start) begin
						state_reg <= wrs_pkg::WRS_XFER;
						xsel_reg <= coinc;
						seq_cnt_reg <= 16'h0000;
					end
				end
				wrs_pkg::WRS_XFER: begin
					if (seq_cnt_reg == 16'(XFER_M1)) begin
						state_reg <= wrs_pkg::WRS_CLEAR;
						csel_reg <= xsel_reg;
						xsel_reg <= '0;
						conv_reg <= 1'b1;
						seq_cnt_reg <= 16'h0000;
					end else begin
						seq_cnt_reg <= seq_cnt_reg + 16'h0001;
					end
				end
				wrs_pkg::WRS_CLEAR: begin
					if (seq_cnt_reg == 16'(CLEAR_M1)) begin
						state_reg <= wrs_pkg::WRS_IDLE;
						csel_reg <= '0;
						seq_cnt_reg <= 16'h0000;
					end else begin
						seq_cnt_reg <= seq_cnt_reg + 16'h0001;
					end
				end
				default: begin
					state_reg <= wrs_pkg::WRS_IDLE;
					xsel_reg <= '0;
					csel_reg <= '0;
				end
			endcase
		end
	end

	// --------------------------------------------------------------
	// Inhibit: three chained stages
	// --------------------------------------------------------------
	// Time-based, like the delay chain it replaces; printer speed is not checked
	always_ff @(posedge CLK) begin
		if (RST) begin
			inh_reg <= 1'b0;
			inh_cnt_reg <= 32'h0000_0000;
			inh_stage_reg <= 2'h0;
		end else if (start) begin
			inh_reg <= 1'b1;
			inh_cnt_reg <= 32'h0000_0000;
			inh_stage_reg <= 2'h0;
		end else if (inh_reg) begin
			if (inh_cnt_reg == 32'(INHIB_STAGE_CYC - 1)) begin
				inh_cnt_reg <= 32'h0000_0000;
				if (inh_stage_reg == 2'(wrs_pkg::INHIB_STAGES - 1)) begin
					inh_reg <= 1'b0;
				end else begin
					inh_stage_reg <= inh_stage_reg + 2'h1;
				end
			end else begin
				inh_cnt_reg <= inh_cnt_reg + 32'h0000_0001;
			end
		end
	end

	// --------------------------------------------------------------
	// Print command and permit
	// --------------------------------------------------------------
	// Conversion ends during an active print are ignored
	always_ff @(posedge CLK) begin
		if (RST) begin
			prt_reg <= 1'b0;
			prt_cnt_reg <= 16'h0000;
		end else if (print_go) begin
			prt_reg <= 1'b1;
			prt_cnt_reg <= 16'h0000;
		end else if (prt_reg) begin
			if (prt_cnt_reg == 16'(PRINT_N - 1)) begin
				prt_reg <= 1'b0;
			end else begin
				prt_cnt_reg <= prt_cnt_reg + 16'h0001;
			end
		end
	end

	// Enable pulse wins over the clear from a print in the same cycle
	always_ff @(posedge CLK) begin
		if (RST) begin
			permit_reg <= 1'b1;
		end else if (SELECT_EN) begin
			permit_reg <= 1'b1;
		end else if (print_go) begin
			permit_reg <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// Hold register and channel marks
	// --------------------------------------------------------------
	// Loading ORs ones in; shifting moves toward the top and fills with zero
	always_ff @(posedge CLK) begin
		if (RST) begin
			hold_reg <= '0;
		end else if (state_reg == wrs_pkg::WRS_XFER) begin
			hold_reg <= hold_reg | MEM_WORD;
		end else if (SHIFT_PULSE) begin
			hold_reg <= {hold_reg[wrs_pkg::HOLD_BITS-2:0], 1'b0};
		end
	end

	// Configurable mark selection, inverted for the memory cells
	always_ff @(posedge CLK) begin
		if (RST) begin
			mark_n_reg <= '1;
		end else begin
			for (int i = 0; i < wrs_pkg::MARKS_OUT; i++) begin
				mark_n_reg[i] <= ~CHAN_MARK[MARK_SEL[i*wrs_pkg::MARK_IDX_W +: wrs_pkg::MARK_IDX_W]];
			end
		end
	end

	// --------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	// Pulse lengths are counted here: a thousand-cycle delay is too long to unroll
	logic [15:0] a_xw_reg;
	logic [15:0] a_cw_reg;
	always_ff @(posedge CLK) begin
		a_xw_reg <= (RST || !(|XFER_SEL)) ? 16'h0000 : a_xw_reg + 16'h0001;
		a_cw_reg <= (RST || !(|CLEAR_SEL)) ? 16'h0000 : a_cw_reg + 16'h0001;
	end
	sequence s_xfer_last;
		(|XFER_SEL) && a_xw_reg == 16'(XFER_M1);
	endsequence
	sequence s_clear_after;
		##1 (!(|XFER_SEL) && (|CLEAR_SEL) && CONV_START);
	endsequence

	a_xfer_then_clear: assert property (s_xfer_last |-> s_clear_after)
		else $error("transfer not followed by clear");
	a_xfer_width: assert property ($fell(|XFER_SEL) |-> a_xw_reg == 16'(XFER_N))
		else $error("transfer pulse width wrong");
	a_clear_width: assert property ($fell(|CLEAR_SEL) |-> a_cw_reg == 16'(CLEAR_N))
		else $error("clear pulse width wrong");
	a_inhibit_with_xfer: assert property ($rose(|XFER_SEL) |-> $rose(INHIBIT))
		else $error("inhibit did not start with transfer");
	a_scan_frozen: assert property (INHIBIT && $past(INHIBIT) |-> $stable(WORD_NUM))
		else $error("scan moved during inhibit");
	a_scan_range: assert property (WORD_NUM[3:0] <= 4'h9 && WORD_NUM <= 6'h24)
		else $error("scan counter out of range");
	a_one_word: assert property ($onehot0(XFER_SEL) && $onehot0(CLEAR_SEL))
		else $error("more than one word selected");
	a_print_lockout: assert property (END_CONV && (SEQ4_LOCK || SYNC_LOCK) |=> !$rose(PRINT_CMD))
		else $error("print issued under lockout");
	a_print_all: assert property (END_CONV && PRINT_ALL && !SEQ4_LOCK && !SYNC_LOCK && !PRINT_CMD |=> $rose(PRINT_CMD))
		else $error("print-all conversion did not print");
	a_permit_block: assert property (END_CONV && !PRINT_ALL && !permit_reg |=> !$rose(PRINT_CMD))
		else $error("print issued without permit");
	a_hold_shift: assert property (SHIFT_PULSE && state_reg != wrs_pkg::WRS_XFER |=>
		hold_reg == {$past(hold_reg[wrs_pkg::HOLD_BITS-2:0]), 1'b0})
		else $error("hold register shift wrong");

endmodule : wrs_readout_seq

// File: wrs_far_model.sv
// Purpose: Far-side model of the memory cells and the serial converter.
// Assumes: One clock; CONV_START is a one-cycle pulse.
// Notes: Cells answer half their bits per cycle, so only an OR-load keeps all.
`timescale 1ns/100ps

module wrs_far_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Memory side
	input wire logic [wrs_pkg::NUM_WORDS-1:0] xfer_sel,
	input wire logic [20:0] word_data,
	output logic [20:0] mem_word,
	// Converter side
	input wire logic conv_start,
	input wire logic ser_bit,
	output logic shift_pulse,
	output logic end_conv,
	output logic [21:0] conv_word
);
	logic [20:0] last_reg;
	logic phase_reg;
	logic busy_reg;
	logic [6:0] step_reg;
	logic [20:0] acc_reg;

	// ------------------------------------------------------------
	// Memory cells
	// ------------------------------------------------------------
	// Unselected cells show a changing pattern, never the last word
	always_comb begin
		if (|xfer_sel) begin
			mem_word = word_data & (phase_reg ? 21'h155555 : 21'h0aaaaa);
		end else begin
			mem_word = ~last_reg;
		end
	end

	// Phase and last value
	always_ff @(posedge clk) begin
		phase_reg <= rst ? 1'b0 : ~phase_reg;
		last_reg <= rst ? 21'h000000 : mem_word;
	end

	// ------------------------------------------------------------
	// Converter
	// ------------------------------------------------------------
	// Shift every fourth cycle; the top stage is read as the shift is raised
	always_ff @(posedge clk) begin
		shift_pulse <= 1'b0;
		end_conv <= 1'b0;
		if (rst) begin
			busy_reg <= 1'b0;
			step_reg <= 7'h00;
			acc_reg <= 21'h000000;
			conv_word <= 22'h000000;
		end else if (conv_start) begin
			busy_reg <= 1'b1;
			step_reg <= 7'h00;
			acc_reg <= 21'h000000;
		end else if (busy_reg) begin
			step_reg <= step_reg + 7'h01;
			if (step_reg[1:0] == 2'h3 && step_reg[6:2] < 5'h15) begin
				shift_pulse <= 1'b1;
				acc_reg <= {acc_reg[19:0], ser_bit};
			end
			if (step_reg == 7'h58) begin
				busy_reg <= 1'b0;
				end_conv <= 1'b1;
				conv_word <= {ser_bit, acc_reg};
			end
		end
	end
endmodule : wrs_far_model

// File: wrs_readout_seq_test.sv
// Purpose: Self-checking bench for the word readout sequencer.
// Assumes: Inhibit stages shortened to 2000 cycles each.
// Notes: Events are matched in order against a queue of expected notes.
`timescale 1ns/100ps

module wrs_readout_seq_test;
	localparam int STAGE = 2000;
	logic CLK = 1'b0;
	logic RST = 1'b1;
	logic [24:0] WORD_DONE = '0;
	logic [20:0] MEM_WORD;
	logic [24:0] XFER_SEL, CLEAR_SEL, PENDING;
	logic [255:0] CHAN_MARK = '0;
	logic [767:0] MARK_SEL = '0;
	logic [95:0] CHAN_MARK_N;
	logic SHIFT_PULSE, END_CONV, CONV_START, SER_BIT;
	logic PRINT_ALL = 1'b0, SEQ4_LOCK = 1'b0, SYNC_LOCK = 1'b0, SELECT_EN = 1'b0;
	logic PRINT_CMD, INHIBIT;
	logic [5:0] WORD_NUM;
	logic [20:0] word_data = '0, data;
	logic [21:0] conv_word;
	logic [31:0] seed = 32'h00000054;
	logic [255:0] cm;
	logic [767:0] ms;
	logic [24:0] pend, xprev = '0;
	logic [5:0] wprev;
	logic pprev = 1'b0;
	logic [39:0] exp_q[$];
	int num_errors = 0, checks_done = 0, xw = 0, cw = 0, pw = 0, iw = 0, j;

	wrs_readout_seq #(.INHIB_STAGE_CYC(STAGE)) u_dut (.CLK(CLK), .RST(RST), .WORD_DONE(WORD_DONE),
		.MEM_WORD(MEM_WORD), .XFER_SEL(XFER_SEL), .CLEAR_SEL(CLEAR_SEL), .PENDING(PENDING),
		.CHAN_MARK(CHAN_MARK), .MARK_SEL(MARK_SEL), .CHAN_MARK_N(CHAN_MARK_N), .SHIFT_PULSE(SHIFT_PULSE),
		.END_CONV(END_CONV), .CONV_START(CONV_START), .SER_BIT(SER_BIT), .PRINT_ALL(PRINT_ALL),
		.SEQ4_LOCK(SEQ4_LOCK), .SYNC_LOCK(SYNC_LOCK), .SELECT_EN(SELECT_EN), .PRINT_CMD(PRINT_CMD),
		.INHIBIT(INHIBIT), .WORD_NUM(WORD_NUM));
	wrs_far_model u_far (.clk(CLK), .rst(RST), .xfer_sel(XFER_SEL), .word_data(word_data),
		.mem_word(MEM_WORD), .conv_start(CONV_START), .ser_bit(SER_BIT), .shift_pulse(SHIFT_PULSE),
		.end_conv(END_CONV), .conv_word(conv_word));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	always #5 CLK = ~CLK;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic report_and_stop();
		if (num_errors == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : report_and_stop

	// An event with nothing noted is a mismatch against an impossible value
	task automatic pop(input logic [39:0] got);
		chk(got, (exp_q.size() > 0) ? exp_q.pop_front() : 40'hffffffffff);
	endtask : pop

	task automatic wait_end();
		int n;
		n = 0;
		while (END_CONV !== 1'b1 && n < 20000) begin
			@(posedge CLK);
			#1;
			n++;
		end
		if (n >= 20000) begin
			chk(40'h0, 40'h1);
			report_and_stop();
		end
	endtask : wait_end

	// ------------------------------------------------------------
	// Monitor: events against the queue, pulse widths by count
	// ------------------------------------------------------------
	always @(posedge CLK) begin
		if (!RST) begin
			if (|XFER_SEL && xprev == 0) pop({8'h01, INHIBIT, WORD_NUM, XFER_SEL});
			if (END_CONV) pop({8'h02, 10'h000, conv_word});
			if (PRINT_CMD && !pprev) pop({8'h03, 32'h0});
			if (|XFER_SEL) xw++;
			else if (xw != 0) begin
				chk(40'(xw), 40'h3e8);
				chk(CLEAR_SEL, xprev);
				chk({39'h0, CONV_START}, 40'h1);
				xw = 0;
			end
			if (|CLEAR_SEL) cw++;
			else if (cw != 0) begin
				chk(40'(cw), 40'h3e8);
				cw = 0;
			end
			if (PRINT_CMD) pw++;
			else if (pw != 0) begin
				chk(40'(pw), 40'h9c4);
				pw = 0;
			end
			if (INHIBIT) iw++;
			else if (iw != 0) begin
				chk(40'(iw), 40'(3 * STAGE));
				iw = 0;
			end
			if (iw > 1) chk(WORD_NUM, wprev);
		end
		xprev = XFER_SEL;
		pprev = PRINT_CMD;
		wprev = WORD_NUM;
	end

	// ------------------------------------------------------------
	// Driver
	// ------------------------------------------------------------
	// Modes per word 3..8, bit j for word 3+j
	initial begin
		repeat (8) @(posedge CLK);
		RST <= 1'b0;
		@(posedge CLK);
		#1;
		chk(WORD_NUM, 6'h00);
		chk(PENDING, 25'h0000000);
		// Random marks and selections
		for (int r = 0; r < 3; r++) begin
			for (int k = 0; k < 8; k++) begin
				cm[32*k +: 32] = seed;
				seed = xs(seed);
			end
			for (int k = 0; k < 96; k++) begin
				ms[8*k +: 8] = seed[7:0];
				seed = xs(seed);
			end
			@(posedge CLK);
			CHAN_MARK <= cm;
			MARK_SEL <= ms;
			repeat (2) @(posedge CLK);
			#1;
			for (int k = 0; k < 96; k++) chk({39'h0, CHAN_MARK_N[k]}, {39'h0, ~cm[ms[8*k +: 8]]});
		end
		// Words 3..8 go pending; word 10 is toggled twice and stays empty
		@(posedge CLK);
		WORD_DONE <= 25'h00005f8;
		@(posedge CLK);
		WORD_DONE <= 25'h0000400;
		@(posedge CLK);
		WORD_DONE <= 25'h0000000;
		repeat (2) @(posedge CLK);
		#1;
		pend = 25'h00001f8;
		chk(PENDING, pend);
		@(posedge CLK);
		for (int i = 3; i < 9; i++) begin
			j = i - 3;
			data = seed[20:0];
			seed = xs(seed);
			word_data <= data;
			PRINT_ALL <= 1'(6'b110010 >> j);
			SEQ4_LOCK <= 1'(6'b010000 >> j);
			SYNC_LOCK <= 1'(6'b100000 >> j);
			SELECT_EN <= 1'(6'b001000 >> j);
			exp_q.push_back({8'h01, 1'b1, 2'(i / 10), 4'(i % 10), (25'h1 << i)});
			exp_q.push_back({8'h02, 10'h000, 1'b0, data});
			if ((6'b001011 >> j) & 6'h01) exp_q.push_back({8'h03, 32'h0});
			@(posedge CLK);
			SELECT_EN <= 1'b0;
			wait_end();
			pend = pend & ~(25'h1 << i);
			chk(PENDING, pend);
			repeat (4) @(posedge CLK);
		end
		repeat (6100) @(posedge CLK);
		chk(exp_q.size(), 40'h0);
		report_and_stop();
	end
endmodule : wrs_readout_seq_test
